// File: pkg/rss_pkg.sv
// reset source sequencer package: register map, reset values, timing,
// sequencer states and the cause flag carrier.
// assumes a single 25 MHz system clock and an axi4-lite register port.
package rss_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 40;    // 25 MHz system clock
  localparam int unsigned RST_STRETCH_NS  = 1000;  // least release stretch
  // least time, so round up to whole cycles
  localparam int unsigned RST_STRETCH_CYC =
    (RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  STRETCH_LOAD    = 8'(RST_STRETCH_CYC - 1);

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;  // cause flags, write 1 clear
  localparam logic [7:0] OFS_MASK   = 8'h04;  // interrupt mask
  localparam logic [7:0] OFS_CTRL   = 8'h08;  // watchdog reset option
  localparam logic [7:0] OFS_STATE  = 8'h0c;  // live sequencer view
  localparam logic [7:0] ADDR_WORD  = 8'hfc;  // drops the byte offset

  // field positions
  localparam int unsigned CTRL_WDT_OPT_BIT = 0;
  localparam int unsigned STATE_RUN_BIT    = 0;
  localparam int unsigned STATE_STOP_BIT   = 1;

  // reset values
  localparam logic [2:0] MASK_RST    = 3'h0;
  localparam logic       WDT_OPT_RST = 1'b1;   // unprogrammed option reads 1
  localparam logic [7:0] CNT_RST     = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD    = 3'h1,  // a reset source is active
    ST_STRETCH = 3'h2,  // sources gone, counting the release delay
    ST_RUN     = 3'h4   // system out of reset
  } rss_state_t;

  // cause flags, same layout in status and mask
  typedef struct packed {
    logic ext;   // external reset pin
    logic wdog;  // watchdog_cause_flag
    logic por;   // power-on or brown-out recovery
  } rss_cause_t;

  localparam rss_cause_t CAUSE_NONE = '{ext: 1'b0, wdog: 1'b0, por: 1'b0};
  localparam rss_cause_t CAUSE_POR  = '{ext: 1'b0, wdog: 1'b0, por: 1'b1};

endpackage : rss_pkg

// File: core/rss_sequencer.sv
// reset source sequencer: merges pin, supply monitor and watchdog
// requests into one system reset and records which source fired.
// assumes async inputs from pins/other clocks, stop_mode from the cpu
// on aclk, and an axi4-lite master on the register port.
//
// Operation
// - low external reset pin resets device
// - brown-out below threshold forces reset
// - held in reset while below power-on (below_por is ignored in stop mode)
// - supply recovery runs full power-on sequence
// - power-on completion sets power-on flag
// - brown-out detection disabled in stop mode
// - watchdog time-out resets only if option set
// - unprogrammed watchdog option reads as one
// - watchdog reset sets watchdog cause flag
// - stop halts system clock, watchdog runs (its time-out is ignored in stop mode)
`timescale 1ns/1ps
`default_nettype none

module rss_sequencer
  import rss_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_reset_n,        // board reset pin
  input  wire logic        brownout_detector,  // below brownout_threshold
  input  wire logic        below_por,          // below power-on threshold
  input  wire logic        wdt_timeout,        // watchdog time-out level
  input  wire logic        stop_mode,          // cpu in stop
  output var  logic        sys_reset_n,        // system reset, low active
  output var  logic        sys_clk_en,         // system clock gate
  output var  logic        irq                 // level interrupt
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // bit 3 ext pin, 2 brown-out, 1 below power-on, 0 watchdog
  localparam logic [3:0] SYNC_RST = 4'h8;   // pin idles high
  logic [3:0] sync1_r;                      // first stage, read by sync2 only
  logic [3:0] sync2_r;                      // usable copies

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {ext_reset_n, brownout_detector, below_por, wdt_timeout};
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // reset requests
  // ----------------------------------------------------------------
  logic       ext_req;   // pin request
  logic       bor_req;   // supply monitor request
  logic       wdt_req;   // watchdog request
  logic       any_req;   // any source active
  logic       wdt_opt_r; // watchdog_reset_option
  rss_cause_t src_now;   // sources seen this cycle

  always_comb begin
    ext_req = ~sync2_r[3];
    bor_req = (sync2_r[2] | sync2_r[1]) & ~stop_mode;
    // watchdog only with option, not in stop
    wdt_req = sync2_r[0] & wdt_opt_r & ~stop_mode;
    any_req = ext_req | bor_req | wdt_req;
    src_now = '{ext: ext_req, wdog: wdt_req, por: bor_req};
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  rss_state_t state_r, state_nxt;  // sequencer state
  logic [7:0] cnt_r, cnt_nxt;      // release stretch counter
  rss_cause_t pend_r, pend_nxt;    // causes of the reset under way
  logic       done;                // sequence completes this cycle

  // aresetn is the true power-up, so start as a power-on reset
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    pend_nxt  = pend_r;
    done      = 1'b0;
    case (state_r)
      ST_HOLD: begin
        pend_nxt = pend_r | src_now;
        if (!any_req) begin
          state_nxt = ST_STRETCH;
          cnt_nxt   = STRETCH_LOAD;
        end
      end
      ST_STRETCH: begin
        if (any_req) begin            // a new source restarts the hold
          state_nxt = ST_HOLD;
          pend_nxt  = pend_r | src_now;
        end else if (cnt_r == CNT_RST) begin
          state_nxt = ST_RUN;
          done      = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_RUN: begin
        if (any_req) begin            // fresh reset, fresh causes
          state_nxt = ST_HOLD;
          pend_nxt  = src_now;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
        pend_nxt  = CAUSE_POR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_HOLD;
      cnt_r   <= CNT_RST;
      pend_r  <= CAUSE_POR;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pend_r  <= pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave and registers
  // ----------------------------------------------------------------
  logic        aw_hold_r, aw_hold_nxt;  // write address latched
  logic        w_hold_r, w_hold_nxt;    // write data latched
  logic [7:0]  waddr_r, waddr_nxt;      // latched write address
  logic [7:0]  wbyte_r, wbyte_nxt;      // latched lane 0 data
  logic        wlane_r, wlane_nxt;      // lane 0 enabled
  logic        awrdy_nxt, wrdy_nxt, bvalid_nxt, arrdy_nxt, rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic        wr_do;                   // write performed this cycle
  logic        wr_status;               // w1c write to status
  rss_cause_t  status_r, status_nxt;    // sticky cause flags
  rss_cause_t  mask_r, mask_nxt;        // interrupt mask
  logic        opt_nxt;                 // next option bit
  logic        rst_n_nxt, clk_en_nxt, irq_nxt;
  logic [7:0]  raddr;                   // word address of read

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    waddr_nxt   = waddr_r;
    wbyte_nxt   = wbyte_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    rvalid_nxt  = s_axi_rvalid;
    rresp_nxt   = s_axi_rresp;
    rdata_nxt   = s_axi_rdata;
    mask_nxt    = mask_r;
    opt_nxt     = wdt_opt_r;
    wr_status   = 1'b0;
    raddr       = s_axi_araddr & ADDR_WORD;
    // address and data may come in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr & ADDR_WORD;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wbyte_nxt  = s_axi_wdata[7:0];
      wlane_nxt  = s_axi_wstrb[0];
    end
    wr_do = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    if (wr_do) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      case (waddr_r)
        OFS_STATUS: wr_status = wlane_r;
        OFS_MASK:   if (wlane_r) mask_nxt = wbyte_r[2:0];
        // option bit writable, reset to one
        OFS_CTRL:   if (wlane_r) opt_nxt = wbyte_r[CTRL_WDT_OPT_BIT];
        OFS_STATE:  ;                       // read only, write ignored
        default:    bresp_nxt = RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    awrdy_nxt = ~aw_hold_nxt & ~bvalid_nxt;
    wrdy_nxt  = ~w_hold_nxt & ~bvalid_nxt;
    // read: answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (raddr)
        OFS_STATUS: rdata_nxt[2:0] = status_r;
        OFS_MASK:   rdata_nxt[2:0] = mask_r;
        OFS_CTRL:   rdata_nxt[CTRL_WDT_OPT_BIT] = wdt_opt_r;
        OFS_STATE: begin
          rdata_nxt[STATE_RUN_BIT]  = (state_r == ST_RUN);
          rdata_nxt[STATE_STOP_BIT] = stop_mode;
        end
        default:    rresp_nxt = RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arrdy_nxt = ~rvalid_nxt;
    // flags set on completion; set wins over clear
    // only a status write clears, never the system reset
    status_nxt = wr_status ? (status_r & ~rss_cause_t'(wbyte_r[2:0]))
                           : status_r;
    if (done) status_nxt = status_nxt | pend_r;
    rst_n_nxt  = (state_nxt == ST_RUN);
    // clock gated in stop; watchdog keeps its own oscillator
    clk_en_nxt = ~stop_mode;
    irq_nxt    = |(status_nxt & mask_nxt);
  end

  // status holds no reset cause after aresetn, then clears only by a status write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      waddr_r       <= 8'h00;
      wbyte_r       <= 8'h00;
      wlane_r       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      status_r      <= CAUSE_NONE;
      mask_r        <= MASK_RST;
      wdt_opt_r     <= WDT_OPT_RST;
      sys_reset_n   <= 1'b0;
      sys_clk_en    <= 1'b1;
      irq           <= 1'b0;
    end else begin
      aw_hold_r     <= aw_hold_nxt;
      w_hold_r      <= w_hold_nxt;
      waddr_r       <= waddr_nxt;
      wbyte_r       <= wbyte_nxt;
      wlane_r       <= wlane_nxt;
      s_axi_awready <= awrdy_nxt;
      s_axi_wready  <= wrdy_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arrdy_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rdata_nxt;
      status_r      <= status_nxt;
      mask_r        <= mask_nxt;
      wdt_opt_r     <= opt_nxt;
      sys_reset_n   <= rst_n_nxt;
      sys_clk_en    <= clk_en_nxt;
      irq           <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned hlp_len_r;  // cycles spent in stretch so far
  always_ff @(posedge aclk) begin
    if (!aresetn) hlp_len_r <= 0;
    else if (state_r == ST_STRETCH) hlp_len_r <= hlp_len_r + 1;
    else hlp_len_r <= 0;
  end
  pin_reset_a: assert property (!ext_reset_n [*3] |=> !sys_reset_n)
    else $error("pin low did not reset");
  pin_sync_a: assert property ($fell(sync2_r[3]) |->
      !$past(ext_reset_n, 2))
    else $error("pin reached logic without two stages");
  bor_reset_a: assert property (bor_req |=> !sys_reset_n)
    else $error("brown-out did not reset");
  por_hold_a: assert property (sync2_r[1] && !stop_mode |=>
      state_r == ST_HOLD)
    else $error("not held below power-on");
  stretch_len_a: assert property ($rose(sys_reset_n) |->
      $past(hlp_len_r) == RST_STRETCH_CYC - 1)
    else $error("release stretch wrong length");
  por_flag_a: assert property (done && pend_r.por |=> status_r.por)
    else $error("power-on flag not set");
  stop_gate_a: assert property (state_r == ST_RUN && stop_mode &&
      sync2_r[3] && !sync2_r[0] |=> sys_reset_n)
    else $error("supply reset raised in stop");
  wdt_opt_a: assert property (state_r == ST_RUN && sync2_r[0] &&
      !stop_mode && !ext_req && !bor_req |=> sys_reset_n == !wdt_opt_r)
    else $error("watchdog reset ignores option");
  opt_dflt_a: assert property (!$past(aresetn) |-> wdt_opt_r)
    else $error("option not one after reset");
  wdt_flag_a: assert property (done && pend_r.wdog |=> status_r.wdog)
    else $error("watchdog flag not set");
  clk_halt_a: assert property (stop_mode |=> !sys_clk_en)
    else $error("clock runs in stop");
  flag_keep_a: assert property (!wr_status |=>
      (status_r & $past(status_r)) == $past(status_r))
    else $error("cause flag lost without clear");
  por_done_c: cover property (done && pend_r.por);
  wdt_done_c: cover property (done && pend_r.wdog);
  ext_done_c: cover property (done && pend_r.ext);
  irq_seen_c: cover property ($rose(irq));

endmodule : rss_sequencer

`default_nettype wire

// File: tb/rss_board.sv
// board side model: reset pin, supply monitor and watchdog time-out.
// assumes the bench commands it on aclk; outputs change after an edge.
`timescale 1ns/1ps
`default_nettype none

module rss_board
  import rss_pkg::*;
(
  input  wire logic aclk,
  input  wire logic press,              // hold the reset pin low
  input  wire logic dip,                // supply under brown-out level
  input  wire logic sag,                // supply under power-on level
  input  wire logic fire,               // one-cycle watchdog request
  output var  logic ext_reset_n,
  output var  logic brownout_detector,
  output var  logic below_por,
  output var  logic wdt_timeout
);
  // ----------------------------------------------------------------
  // supply and pin levels
  // ----------------------------------------------------------------
  logic [1:0] wdt_cnt_r;  // stretch: the design wants 3 cycles at least

  initial begin
    ext_reset_n       = 1'b1;
    brownout_detector = 1'b0;
    below_por         = 1'b0;
    wdt_timeout       = 1'b0;
    wdt_cnt_r         = 2'h0;
  end

  // below power-on is always below brown-out too
  always @(posedge aclk) begin
    ext_reset_n       <= ~press;
    brownout_detector <= dip | sag;
    below_por         <= sag;
    if (fire) begin
      wdt_cnt_r <= 2'h3;
    end else if (wdt_cnt_r != 2'h0) begin
      wdt_cnt_r <= wdt_cnt_r - 2'h1;
    end
    wdt_timeout <= fire | (wdt_cnt_r != 2'h0);
  end
endmodule : rss_board

`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the reset source sequencer.
// assumes rss_pkg and rss_board compiled first; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rss_pkg::*;
  logic        aclk, aresetn, stop_mode, press, dip, sag, fire;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        ext_reset_n, brownout_detector, below_por, wdt_timeout;
  logic        sys_reset_n, sys_clk_en, irq;
  int          bad_count, samples_checked, cyc;

  rss_sequencer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reset_n,
    .brownout_detector, .below_por, .wdt_timeout, .stop_mode,
    .sys_reset_n, .sys_clk_en, .irq);
  rss_board board_u (.aclk, .press, .dip, .sag, .fire, .ext_reset_n,
    .brownout_detector, .below_por, .wdt_timeout);

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // about 350 cycles expected, so 4000 leaves ample slack
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    s_axi_rready <= 1'b0;
  endtask : rd

  // leaves early once the level shows, else after lim cycles
  task automatic wait_rst(input logic lvl, input int lim);
    for (int i = 0; i < lim && sys_reset_n !== lvl; i++) @(posedge aclk);
  endtask : wait_rst

  // after the caller releases a source, check the stretch before the rise
  task automatic see_release;
    repeat (20) @(posedge aclk);
    chk("stretch", 32'h0, 32'(sys_reset_n));
    wait_rst(1'b1, 20);
    chk("sys_reset_n", 32'h1, 32'(sys_reset_n));
  endtask : see_release

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup;
    chk("sys_reset_n", 32'h0, 32'(sys_reset_n));
    wait_rst(1'b1, 60);
    chk("sys_reset_n", 32'h1, 32'(sys_reset_n));
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    rd(OFS_CTRL, 32'h1, RESP_OKAY);
    rd(OFS_STATE, 32'h1, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
  endtask : t_powerup

  task automatic t_pin;
    wr(OFS_MASK, 32'h7);
    wr(OFS_STATUS, 32'h7);
    chk("irq", 32'h0, 32'(irq));
    press <= 1'b1;
    wait_rst(1'b0, 8);
    chk("sys_reset_n", 32'h0, 32'(sys_reset_n));
    press <= 1'b0;
    see_release();
    rd(OFS_STATUS, 32'h4, RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_STATUS, 32'h4);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
  endtask : t_pin

  task automatic t_supply;
    dip <= 1'b1;
    wait_rst(1'b0, 8);
    chk("sys_reset_n", 32'h0, 32'(sys_reset_n));
    dip <= 1'b0;
    see_release();
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    wr(OFS_STATUS, 32'h1);
    sag <= 1'b1;
    repeat (80) @(posedge aclk);
    chk("held", 32'h0, 32'(sys_reset_n));
    sag <= 1'b0;
    see_release();
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    wr(OFS_STATUS, 32'h1);
  endtask : t_supply

  task automatic t_stop;
    stop_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("sys_clk_en", 32'h0, 32'(sys_clk_en));
    dip <= 1'b1;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    wait_rst(1'b0, 12);
    chk("stop gate", 32'h1, 32'(sys_reset_n));
    dip <= 1'b0;
    repeat (6) @(posedge aclk);
    stop_mode <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("sys_clk_en", 32'h1, 32'(sys_clk_en));
    chk("sys_reset_n", 32'h1, 32'(sys_reset_n));
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
  endtask : t_stop

  task automatic t_wdt;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    wait_rst(1'b0, 8);
    chk("wdt reset", 32'h0, 32'(sys_reset_n));
    wait_rst(1'b1, 40);
    chk("sys_reset_n", 32'h1, 32'(sys_reset_n));
    rd(OFS_STATUS, 32'h2, RESP_OKAY);
    wr(OFS_STATUS, 32'h2);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_CTRL, 32'h0, RESP_OKAY);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    wait_rst(1'b0, 12);
    chk("wdt gated", 32'h1, 32'(sys_reset_n));
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
  endtask : t_wdt

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0; stop_mode = 1'b0; press = 1'b0; dip = 1'b0;
    sag = 1'b0; fire = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0; s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; bad_count = 0; samples_checked = 0; cyc = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_powerup();
    t_pin();
    t_supply();
    t_stop();
    t_wdt();
    conclude();
  end
endmodule : tb

`default_nettype wire
